// ---- design/bank_event_if.sv ----
`timescale 1ns/1ps
// Purpose: Carries decoded per-bank events from the top to each bank tracker
// Assumes: One clock domain
// Notes: One instance per bank
interface bank_event_if;
  logic doAct;
  logic doRead;
  logic doWrite;
  logic autoPre;
  logic doPre;
  logic interrupt;
  logic stop;
  logic burstDone;
  sdram_ctl_pkg::bank_state_t state;
  modport ctrl (output doAct, output doRead, output doWrite, output autoPre, output doPre,
    output interrupt, output stop, output burstDone, input state);
  modport bank (input doAct, input doRead, input doWrite, input autoPre, input doPre,
    input interrupt, input stop, input burstDone, output state);
endinterface

// ---- design/bank_tracker.sv ----
`timescale 1ns/1ps
// Purpose: State of one bank: activation, bursts, auto and explicit precharge
// Assumes: Controller keeps same-bank timing legal
// Notes: Recovery delay precedes concurrent precharge of an interrupted write
module bank_tracker (
  input wire logic core_clk,
  input wire logic srst,
  bank_event_if.bank ev
);
  typedef struct packed {
    sdram_ctl_pkg::bank_state_t state;
    logic [sdram_ctl_pkg::CNT_W-1:0] cnt;
  } bank_t;
  bank_t st_reg;
  bank_t st_next;

  assign ev.state = st_reg.state;

  always_comb begin
    st_next = st_reg;
    if (st_reg.cnt != sdram_ctl_pkg::CNT_ZERO) begin
      st_next.cnt = st_reg.cnt - sdram_ctl_pkg::CNT_ONE;
    end
    case (st_reg.state)
      sdram_ctl_pkg::BANK_IDLE: begin
        // Precharge to an idle bank is ignored: no branch takes doPre here
        if (ev.doAct) begin // RQ2
          st_next.state = sdram_ctl_pkg::BANK_ACTIVATING;
          st_next.cnt = sdram_ctl_pkg::ACT_CYC;
        end
      end
      sdram_ctl_pkg::BANK_ACTIVATING: begin
        if (st_reg.cnt <= sdram_ctl_pkg::CNT_ONE) begin
          st_next.state = sdram_ctl_pkg::BANK_ACTIVE;
        end
      end
      sdram_ctl_pkg::BANK_ACTIVE, sdram_ctl_pkg::BANK_READ, sdram_ctl_pkg::BANK_WRITE: begin
        if (ev.doRead) begin
          st_next.state = ev.autoPre ? sdram_ctl_pkg::BANK_READ_AP : sdram_ctl_pkg::BANK_READ;
        end else if (ev.doWrite) begin
          st_next.state = ev.autoPre ? sdram_ctl_pkg::BANK_WRITE_AP : sdram_ctl_pkg::BANK_WRITE;
        end else if (ev.doPre) begin
          st_next.state = sdram_ctl_pkg::BANK_PRECHARGING;
          st_next.cnt = sdram_ctl_pkg::PRECHARGE_CYC;
        end else if (ev.interrupt || ev.stop || ev.burstDone) begin
          if (st_reg.state != sdram_ctl_pkg::BANK_ACTIVE) begin
            st_next.state = sdram_ctl_pkg::BANK_ACTIVE;
          end
        end
      end
      sdram_ctl_pkg::BANK_READ_AP: begin
        if (ev.interrupt || ev.burstDone || ev.stop) begin // RQ6 RQ12
          st_next.state = sdram_ctl_pkg::BANK_PRECHARGING;
          st_next.cnt = sdram_ctl_pkg::PRECHARGE_CYC;
        end
      end
      sdram_ctl_pkg::BANK_WRITE_AP: begin
        if (ev.interrupt || ev.burstDone || ev.stop) begin // RQ6 RQ13
          st_next.state = sdram_ctl_pkg::BANK_RECOVER;
          st_next.cnt = sdram_ctl_pkg::WRITE_RECOVERY_CYC;
        end
      end
      sdram_ctl_pkg::BANK_RECOVER: begin
        if (st_reg.cnt <= sdram_ctl_pkg::CNT_ONE) begin // RQ13
          st_next.state = sdram_ctl_pkg::BANK_PRECHARGING;
          st_next.cnt = sdram_ctl_pkg::PRECHARGE_CYC;
        end
      end
      sdram_ctl_pkg::BANK_PRECHARGING: begin
        if (st_reg.cnt <= sdram_ctl_pkg::CNT_ONE) begin
          st_next.state = sdram_ctl_pkg::BANK_IDLE;
        end
      end
      default: st_next.state = sdram_ctl_pkg::BANK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg.state <= sdram_ctl_pkg::BANK_IDLE;
      st_reg.cnt <= sdram_ctl_pkg::CNT_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // bank_tracker

// ---- design/sdram_bank_cke_control.sv ----
`timescale 1ns/1ps
// Purpose: Inter-bank command legality, burst data timing and CKE power states
// Assumes: Pins sampled on core_clk; same-bank timing kept by the controller
// Notes: Read data comes from a FIFO standing in for the array
//
// Summary of operation
// RQ1: Refresh, self refresh, mode load need all idle
// RQ2: CS,RAS low, CAS,WE high activates bank
// RQ3: Idle bank never blocks other-bank commands
// RQ4: Precharge elsewhere leaves running burst alone
// RQ5: Burst stop hits only the running burst
// RQ6: Interrupted auto-precharge burst precharges itself
// RQ7: Read-on-read ends old data after latency
// RQ8: Write ends a read at once; mask earlier
// RQ9: Write ends auto-precharge read; precharge starts then
// RQ10: Read ends write; last data one before
// RQ11: Write ends write; last data one before
// RQ12: Read ends auto-precharge read; precharge starts then
// RQ13: Interrupted auto-precharge write waits recovery first
// RQ14: CKE low twice keeps low-power state
// RQ15: CKE fall: power-down, self refresh, or suspend
// RQ16: Stop with CKE low idle enters shutdown
// RQ17: Power-down exit idle by next edge
// RQ18: Self refresh exit waits exit time, NOPs
// RQ19: Suspend exit resumes, next command decoded
// RQ20: Precharge to idle bank is no-op
// RQ21: Controller precharges all only from legal states
// RQ22: Self refresh is refresh with CKE low
// RQ23: Burst stop truncates the latest burst
module sdram_bank_cke_control (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clockEnable,
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeEnableN,
  input wire logic [sdram_ctl_pkg::BANK_W-1:0] bankAddr,
  input wire logic [sdram_ctl_pkg::ADDR_W-1:0] addr,
  input wire logic [sdram_ctl_pkg::DATA_W-1:0] dataIn,
  output logic [sdram_ctl_pkg::DATA_W-1:0] dataOut,
  output logic dataOutEn,
  output logic dataOutEnN,
  output logic allIdle,
  output logic [2:0] powerState,
  output logic cmdRejected,
  output logic writeAccepted,
  output logic [sdram_ctl_pkg::BANK_W-1:0] writeBank,
  output logic [sdram_ctl_pkg::DATA_W-1:0] writeData
);
  localparam int NB = sdram_ctl_pkg::NUM_BANKS;

  typedef struct packed {
    sdram_ctl_pkg::power_state_t pwr;
    logic ckePrev;
    logic [sdram_ctl_pkg::CNT_W-1:0] pwrCnt;
    logic [1:0] nopCnt;
    logic readActive;
    logic writeActive;
    logic [sdram_ctl_pkg::BANK_W-1:0] burstBank;
    logic [3:0] burstLeft;
    logic [3:0] readLeft;
    logic [2:0] readDelay;
    logic [sdram_ctl_pkg::DATA_W-1:0] dataOut;
    logic dataOutEn;
    logic allIdle;
    logic cmdRejected;
    logic writeAccepted;
    logic [sdram_ctl_pkg::BANK_W-1:0] writeBank;
    logic [sdram_ctl_pkg::DATA_W-1:0] writeData;
  } top_t;
  top_t st_reg;
  top_t st_next;

  logic [3:0] cmd;
  logic isNop;
  logic cmdLive;
  logic anyIdle;
  logic everyIdle;
  logic [NB-1:0] idleVec;
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [sdram_ctl_pkg::DATA_W-1:0] fifoOutData;
  logic issueRead;
  logic issueWrite;
  logic issueStop;
  logic dataBeat;

  // ****************************************
  // Command decode
  // ****************************************
  assign cmd = {chipSelectN, rowStrobeN, colStrobeN, writeEnableN};
  assign isNop = chipSelectN || (cmd == sdram_ctl_pkg::CMD_NOP);
  assign everyIdle = &idleVec;
  assign anyIdle = |idleVec;
  // Commands only execute with CKE high at this and the previous edge
  assign cmdLive = clockEnable && st_reg.ckePrev &&
    (st_reg.pwr == sdram_ctl_pkg::PWR_NORMAL);
  assign issueRead = cmdLive && cmd == sdram_ctl_pkg::CMD_READ;
  assign issueWrite = cmdLive && cmd == sdram_ctl_pkg::CMD_WRITE;
  assign issueStop = cmdLive && cmd == sdram_ctl_pkg::CMD_STOP;

  // ****************************************
  // Bank trackers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_bank
      bank_event_if bev ();
      logic sel;
      logic running;
      assign sel = bankAddr == sdram_ctl_pkg::BANK_W'(gi);
      assign running = (st_reg.readActive || st_reg.writeActive) &&
        st_reg.burstBank == sdram_ctl_pkg::BANK_W'(gi);
      assign bev.doAct = cmdLive && sel && cmd == sdram_ctl_pkg::CMD_ACT; // RQ2 RQ3
      assign bev.doRead = issueRead && sel;
      assign bev.doWrite = issueWrite && sel;
      assign bev.autoPre = addr[sdram_ctl_pkg::AP_BIT];
      // Single precharge only hits its bank; others keep bursting
      assign bev.doPre = cmdLive && cmd == sdram_ctl_pkg::CMD_PRE &&
        (sel || addr[sdram_ctl_pkg::AP_BIT]); // RQ4 RQ20
      // New burst elsewhere ends this one at registration
      assign bev.interrupt = (issueRead || issueWrite) && !sel && running; // RQ6 RQ12 RQ13
      assign bev.stop = issueStop && running; // RQ5 RQ23
      assign bev.burstDone = running && dataBeat && st_reg.burstLeft == 4'h1;
      assign idleVec[gi] = bev.state == sdram_ctl_pkg::BANK_IDLE;
      bank_tracker u_bank (
        .core_clk(core_clk),
        .srst(srst),
        .ev(bev)
      );
    end
  endgenerate

  // ****************************************
  // Read data path
  // ****************************************
  // Write data loops into the FIFO; a stalled FIFO rejects further writes
  assign fifoInValid = st_reg.writeAccepted;
  assign fifoOutReady = st_reg.readDelay == 3'h1 && st_reg.readLeft != 4'h0;
  assign dataBeat = (st_reg.readActive && st_reg.readDelay == 3'h0) || st_reg.writeActive;

  sync_fifo #(
    .WIDTH(sdram_ctl_pkg::DATA_W),
    .DEPTH(sdram_ctl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(st_reg.writeData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // ****************************************
  // Burst and power state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.ckePrev = clockEnable; // RQ14
    st_next.cmdRejected = 1'b0;
    st_next.writeAccepted = 1'b0;
    st_next.allIdle = everyIdle;
    if (st_reg.pwrCnt != sdram_ctl_pkg::CNT_ZERO) begin
      st_next.pwrCnt = st_reg.pwrCnt - sdram_ctl_pkg::CNT_ONE;
    end
    case (st_reg.pwr)
      sdram_ctl_pkg::PWR_NORMAL: begin
        if (st_reg.ckePrev && !clockEnable) begin // RQ15
          if (st_reg.readActive || st_reg.writeActive) begin
            st_next.pwr = sdram_ctl_pkg::PWR_CLOCK_SUSPEND;
          end else if (everyIdle && isNop) begin
            st_next.pwr = sdram_ctl_pkg::PWR_POWER_DOWN;
          end else if (everyIdle && cmd == sdram_ctl_pkg::CMD_REF) begin // RQ22
            st_next.pwr = sdram_ctl_pkg::PWR_SELF_REFRESH;
          end else if (everyIdle && cmd == sdram_ctl_pkg::CMD_STOP) begin // RQ16
            st_next.pwr = sdram_ctl_pkg::PWR_ARRAY_SHUTDOWN;
          end else begin
            st_next.cmdRejected = 1'b1;
          end
        end else if (cmdLive && !isNop) begin
          if ((cmd == sdram_ctl_pkg::CMD_REF || cmd == sdram_ctl_pkg::CMD_LMR) &&
              !everyIdle) begin // RQ1
            st_next.cmdRejected = 1'b1;
          end else if (cmd == sdram_ctl_pkg::CMD_REF) begin
            st_next.pwr = sdram_ctl_pkg::PWR_REFRESHING;
            st_next.pwrCnt = sdram_ctl_pkg::PRECHARGE_CYC;
          end else if (issueStop && !(st_reg.readActive || st_reg.writeActive)) begin
            st_next.cmdRejected = 1'b1;
          end
          if (issueRead || issueWrite) begin // RQ3
            if (idleVec[bankAddr] && !anyIdle) begin
              st_next.cmdRejected = 1'b1;
            end
          end
        end
        if (cmdLive) begin
          if (issueRead) begin
            // Old read keeps driving until latency expires
            st_next.readActive = 1'b1; // RQ7 RQ10 RQ12
            st_next.writeActive = 1'b0;
            st_next.readDelay = sdram_ctl_pkg::READ_LATENCY_DEF;
            st_next.readLeft = sdram_ctl_pkg::BURST_LEN_DEF;
            st_next.burstLeft = sdram_ctl_pkg::BURST_LEN_DEF;
            st_next.burstBank = bankAddr;
          end else if (issueWrite) begin
            // Read output cut immediately; write data taken this edge
            st_next.readActive = 1'b0; // RQ8 RQ9 RQ11
            st_next.readLeft = 4'h0;
            st_next.dataOutEn = 1'b0;
            st_next.writeActive = 1'b1;
            st_next.burstLeft = sdram_ctl_pkg::BURST_LEN_DEF;
            st_next.burstBank = bankAddr;
          end else if (issueStop) begin // RQ5 RQ23
            st_next.readActive = 1'b0;
            st_next.writeActive = 1'b0;
            st_next.readLeft = 4'h0;
          end
        end
      end
      sdram_ctl_pkg::PWR_POWER_DOWN: begin
        if (clockEnable && isNop) begin // RQ17
          st_next.pwr = sdram_ctl_pkg::PWR_NORMAL;
        end
      end
      sdram_ctl_pkg::PWR_SELF_REFRESH: begin
        if (clockEnable && isNop) begin // RQ18
          st_next.pwr = sdram_ctl_pkg::PWR_SR_EXIT;
          st_next.pwrCnt = sdram_ctl_pkg::SELF_REFRESH_EXIT_CYC;
          st_next.nopCnt = 2'h0;
        end
      end
      sdram_ctl_pkg::PWR_SR_EXIT: begin
        if (!isNop) begin // RQ18
          st_next.cmdRejected = 1'b1;
        end else if (!chipSelectN && st_reg.nopCnt != sdram_ctl_pkg::NOP_MIN) begin
          st_next.nopCnt = st_reg.nopCnt + 2'h1;
        end
        if (st_reg.pwrCnt <= sdram_ctl_pkg::CNT_ONE &&
            st_reg.nopCnt == sdram_ctl_pkg::NOP_MIN) begin
          st_next.pwr = sdram_ctl_pkg::PWR_NORMAL;
        end
      end
      sdram_ctl_pkg::PWR_REFRESHING: begin
        if (st_reg.pwrCnt <= sdram_ctl_pkg::CNT_ONE) begin
          st_next.pwr = sdram_ctl_pkg::PWR_NORMAL;
        end
      end
      sdram_ctl_pkg::PWR_CLOCK_SUSPEND: begin
        if (clockEnable) begin // RQ19
          st_next.pwr = sdram_ctl_pkg::PWR_NORMAL;
        end
      end
      sdram_ctl_pkg::PWR_ARRAY_SHUTDOWN: begin
        if (clockEnable) begin // RQ16
          st_next.pwr = sdram_ctl_pkg::PWR_NORMAL;
        end
      end
      default: st_next.pwr = sdram_ctl_pkg::PWR_NORMAL;
    endcase

    // Data movement freezes while suspended; both-low edges hold state
    if (st_reg.pwr == sdram_ctl_pkg::PWR_NORMAL && clockEnable) begin // RQ14
      if (st_reg.readActive && st_reg.readDelay != 3'h0 && !issueRead) begin
        st_next.readDelay = st_reg.readDelay - 3'h1;
      end
      if (fifoOutReady && !issueWrite) begin // RQ7
        st_next.dataOut = fifoOutValid ? fifoOutData : '0;
        st_next.dataOutEn = 1'b1;
        st_next.readDelay = 3'h1;
        st_next.readLeft = st_reg.readLeft - 4'h1;
      end else if (st_reg.readLeft == 4'h0 || issueWrite) begin
        st_next.dataOutEn = 1'b0;
      end
      if ((issueWrite || st_reg.writeActive) && !issueRead && !issueStop) begin
        // Data sampled one clock before an interrupt is the last kept
        if (fifoInReady) begin // RQ10 RQ11
          st_next.writeAccepted = 1'b1;
          st_next.writeBank = issueWrite ? bankAddr : st_reg.burstBank;
          st_next.writeData = dataIn;
        end else begin
          st_next.cmdRejected = 1'b1;
        end
      end
      if (dataBeat && st_reg.burstLeft != 4'h0 && !issueRead && !issueWrite) begin
        st_next.burstLeft = st_reg.burstLeft - 4'h1;
        if (st_reg.burstLeft == 4'h1) begin
          st_next.writeActive = 1'b0;
          st_next.readActive = 1'b0;
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.pwr <= sdram_ctl_pkg::PWR_NORMAL;
      st_reg.allIdle <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dataOut = st_reg.dataOut;
  assign dataOutEn = st_reg.dataOutEn;
  assign dataOutEnN = !st_reg.dataOutEn;
  assign allIdle = st_reg.allIdle;
  assign powerState = 3'(st_reg.pwr);
  assign cmdRejected = st_reg.cmdRejected;
  assign writeAccepted = st_reg.writeAccepted;
  assign writeBank = st_reg.writeBank;
  assign writeData = st_reg.writeData;
endmodule // sdram_bank_cke_control

// ---- design/sdram_ctl_pkg.sv ----
// Purpose: Shared constants and types for the bank/CKE state logic
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes: Command codes are {cs_n, ras_n, cas_n, we_n}
package sdram_ctl_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  // Figures in ns; cycle counts derived below
  localparam int PRECHARGE_TIME_NS = 18;
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 120;
  localparam int ACT_TIME_NS = 18;
  localparam logic [CNT_W-1:0] PRECHARGE_CYC =
    CNT_W'((PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYC =
    CNT_W'((WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SELF_REFRESH_EXIT_CYC =
    CNT_W'((SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACT_CYC =
    CNT_W'((ACT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [2:0] READ_LATENCY_DEF = 3'h3;
  localparam logic [3:0] BURST_LEN_DEF = 4'h4;
  localparam logic [1:0] NOP_MIN = 2'h2;
  localparam int AP_BIT = 10;
  localparam int ADDR_W = 13;

  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_STOP = 4'h6;

  typedef enum {
    BANK_IDLE, BANK_ACTIVATING, BANK_ACTIVE, BANK_READ, BANK_WRITE,
    BANK_READ_AP, BANK_WRITE_AP, BANK_RECOVER, BANK_PRECHARGING
  } bank_state_t;

  typedef enum {
    PWR_NORMAL, PWR_POWER_DOWN, PWR_SELF_REFRESH, PWR_SR_EXIT,
    PWR_CLOCK_SUSPEND, PWR_ARRAY_SHUTDOWN, PWR_REFRESHING
  } power_state_t;
endpackage

// ---- design/sync_fifo.sv ----
`timescale 1ns/1ps
// Purpose: Flop-based FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes: Full and empty are exact; no bypass path
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } fifo_t;
  fifo_t st_reg;
  fifo_t st_next;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (st_reg.wrPtr[AW] != st_reg.rdPtr[AW]) &&
    (st_reg.wrPtr[AW-1:0] == st_reg.rdPtr[AW-1:0]);
  assign empty = st_reg.wrPtr == st_reg.rdPtr;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = st_reg.mem[st_reg.rdPtr[AW-1:0]];
  assign push = inValid && !full;
  assign pop = outReady && !empty;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wrPtr[AW-1:0]] = inData;
      st_next.wrPtr = st_reg.wrPtr + 1'b1;
    end
    if (pop) begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // sync_fifo

// ---- dv/sdram_bank_cke_control_checker.sv ----
// Purpose: Port-level assertions
// Assumes: One clock, srst sync high
// Notes: Bound below
`timescale 1ns/1ps
module sdram_bank_cke_control_checker (
  input logic core_clk,
  input logic srst,
  input logic clockEnable,
  input logic chipSelectN,
  input logic rowStrobeN,
  input logic colStrobeN,
  input logic writeEnableN,
  input logic [sdram_ctl_pkg::BANK_W-1:0] bankAddr,
  input logic [sdram_ctl_pkg::DATA_W-1:0] dataIn,
  input logic dataOutEn,
  input logic dataOutEnN,
  input logic allIdle,
  input logic [2:0] powerState,
  input logic cmdRejected,
  input logic writeAccepted,
  input logic [sdram_ctl_pkg::BANK_W-1:0] writeBank,
  input logic [sdram_ctl_pkg::DATA_W-1:0] writeData
);
  // *****
  // Properties
  // *****
  logic ckePrev;
  logic [3:0] cmd;
  logic taken;
  assign cmd = {chipSelectN, rowStrobeN, colStrobeN, writeEnableN};
  assign taken = clockEnable && ckePrev && (powerState == 3'h0);
  // Low in reset, as the design's copy is
  always_ff @(posedge core_clk) begin
    ckePrev <= !srst && clockEnable;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_fall(logic [3:0] c);
    ckePrev && !clockEnable && allIdle && powerState == 3'h0 && cmd == c;
  endsequence
  sequence s_take(logic [3:0] c);
    taken && (cmd == c);
  endsequence
  property p_pdown_entry;
    s_fall(sdram_ctl_pkg::CMD_NOP) |=> powerState == 3'h1;
  endproperty
  a_pdown_entry: assert property (p_pdown_entry) else $error("no power-down");
  property p_sref_entry;
    s_fall(sdram_ctl_pkg::CMD_REF) |=> powerState == 3'h2;
  endproperty
  a_sref_entry: assert property (p_sref_entry) else $error("no self refresh");
  property p_shut_entry;
    s_fall(sdram_ctl_pkg::CMD_STOP) |=> powerState == 3'h5;
  endproperty
  a_shut_entry: assert property (p_shut_entry) else $error("no shutdown");
  property p_hold;
    !ckePrev && !clockEnable && (powerState != 3'h0) |=> $stable(powerState);
  endproperty
  a_hold: assert property (p_hold) else $error("low-power state left");
  property p_pdown_exit;
    !ckePrev && clockEnable && (powerState == 3'h1) && (cmd == sdram_ctl_pkg::CMD_NOP)
      |=> powerState == 3'h0;
  endproperty
  a_pdown_exit: assert property (p_pdown_exit) else $error("slow power-down exit");
  property p_read_lat;
    s_take(sdram_ctl_pkg::CMD_READ) ##1 (!taken || cmd == sdram_ctl_pkg::CMD_NOP)
      |=> ##2 (dataOutEn && !dataOutEnN);
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read data late");
  property p_write_word;
    s_take(sdram_ctl_pkg::CMD_WRITE)
      |=> writeAccepted && writeBank == $past(bankAddr) && writeData == $past(dataIn);
  endproperty
  a_write_word: assert property (p_write_word) else $error("write word lost");
  property p_ref_busy;
    s_take(sdram_ctl_pkg::CMD_REF) ##0 !allIdle |=> cmdRejected;
  endproperty
  a_ref_busy: assert property (p_ref_busy) else $error("busy refresh taken");
  property p_stop_idle;
    s_take(sdram_ctl_pkg::CMD_STOP) ##0 allIdle |=> cmdRejected;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("idle stop taken");
  property p_srx_refuse;
    (powerState == 3'h3) && !chipSelectN && (cmd != sdram_ctl_pkg::CMD_NOP) |=> cmdRejected;
  endproperty
  a_srx_refuse: assert property (p_srx_refuse) else $error("exit command taken");
endmodule // sdram_bank_cke_control_checker

bind sdram_bank_cke_control sdram_bank_cke_control_checker i_chk (.core_clk, .srst,
  .clockEnable, .chipSelectN, .rowStrobeN, .colStrobeN, .writeEnableN, .bankAddr, .dataIn,
  .dataOutEn, .dataOutEnN, .allIdle, .powerState, .cmdRejected, .writeAccepted, .writeBank,
  .writeData);

// ---- dv/sdram_bank_cke_control_test.sv ----
// Purpose: Self-checking bench
// Assumes: Commands via sdram_ctl_model
// Notes: Outputs read 1 ns after the edge
`timescale 1ns/1ps
module sdram_bank_cke_control_test;
  // *****
  // Bench
  // *****
  localparam logic [3:0] NOP = sdram_ctl_pkg::CMD_NOP, ACT = sdram_ctl_pkg::CMD_ACT,
    RD = sdram_ctl_pkg::CMD_READ, WR = sdram_ctl_pkg::CMD_WRITE, PRE = sdram_ctl_pkg::CMD_PRE,
    REF = sdram_ctl_pkg::CMD_REF, STOP = sdram_ctl_pkg::CMD_STOP;
  logic core_clk, srst, clockEnable, chipSelectN, rowStrobeN, colStrobeN, writeEnableN;
  logic dataOutEn, dataOutEnN, allIdle, cmdRejected, writeAccepted;
  logic [1:0] bankAddr, writeBank;
  logic [12:0] addr;
  logic [15:0] dataIn, dataOut, writeData;
  logic [2:0] powerState;
  int badCount, nTests, cycles;
  sdram_ctl_model i_ctl (.core_clk, .clockEnable, .chipSelectN, .rowStrobeN, .colStrobeN,
    .writeEnableN, .bankAddr, .addr, .dataIn);
  sdram_bank_cke_control i_dut (.core_clk, .srst, .clockEnable, .chipSelectN, .rowStrobeN,
    .colStrobeN, .writeEnableN, .bankAddr, .addr, .dataIn, .dataOut, .dataOutEn, .dataOutEnN,
    .allIdle, .powerState, .cmdRejected, .writeAccepted, .writeBank, .writeData);
  task automatic chk(input logic [15:0] got, exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] c, logic [1:0] b, logic cke);
    i_ctl.issue(c, b, 1'b0, cke, 1'b0, 16'h0000);
  endtask
  task automatic nop(input int n);
    repeat (n) cmd(NOP, 2'h0, 1'b1);
  endtask
  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ps(input logic [2:0] e);
    chk(16'(powerState), 16'(e));
  endtask
  task automatic testPower;
    nop(1);
    cmd(NOP, 2'h0, 1'b0);
    ps(3'h1);
    cmd(ACT, 2'h0, 1'b0);
    ps(3'h1);
    cmd(NOP, 2'h0, 1'b1);
    ps(3'h0);
    nop(2);
    $display("power-down test done");
  endtask
  task automatic testSref;
    int k = 0;
    int t = int'(sdram_ctl_pkg::SELF_REFRESH_EXIT_CYC);
    cmd(REF, 2'h0, 1'b0);
    ps(3'h2);
    cmd(NOP, 2'h0, 1'b0);
    ps(3'h2);
    cmd(NOP, 2'h0, 1'b1);
    ps(3'h3);
    cmd(PRE, 2'h0, 1'b1);
    chk(16'(cmdRejected), 16'h1);
    while (powerState !== 3'h0 && k < 40) begin
      nop(1);
      k++;
    end
    chk(16'(k + 2 >= t && k <= t + 1), 16'h1);
    $display("self refresh test done");
  endtask
  task automatic testShutdown;
    cmd(STOP, 2'h0, 1'b0);
    ps(3'h5);
    cmd(NOP, 2'h0, 1'b0);
    ps(3'h5);
    cmd(RD, 2'h0, 1'b1);
    nop(1);
    ps(3'h0);
    $display("shutdown test done");
  endtask
  task automatic testBanks;
    int n = 0;
    cmd(STOP, 2'h0, 1'b1);
    chk(16'(cmdRejected), 16'h1);
    cmd(ACT, 2'h0, 1'b1);
    cmd(ACT, 2'h1, 1'b1);
    nop(3);
    chk(16'(allIdle), 16'h0);
    cmd(REF, 2'h0, 1'b1);
    chk(16'(cmdRejected), 16'h1);
    i_ctl.issue(WR, 2'h0, 1'b0, 1'b1, 1'b1, 16'h1111);
    chk(writeData, 16'h1111);
    i_ctl.issue(WR, 2'h1, 1'b0, 1'b1, 1'b1, 16'h2222);
    chk(16'({writeBank, writeData}), 16'h2222);
    chk(16'(writeBank), 16'h1);
    i_ctl.issue(NOP, 2'h0, 1'b0, 1'b1, 1'b1, 16'h3333);
    i_ctl.issue(RD, 2'h0, 1'b0, 1'b1, 1'b1, 16'h4444);
    chk(16'(writeAccepted), 16'h0);
    cmd(RD, 2'h1, 1'b1);
    nop(3);
    chk(dataOut, 16'h1111);
    repeat (8) begin
      n += int'(dataOutEn);
      nop(1);
    end
    chk(16'(n), 16'h4);
    i_ctl.issue(WR, 2'h0, 1'b1, 1'b1, 1'b1, 16'h6666);
    i_ctl.issue(RD, 2'h1, 1'b1, 1'b1, 1'b1, 16'h7777);
    nop(20);
    chk(16'(allIdle), 16'h1);
    cmd(PRE, 2'h2, 1'b1);
    chk(16'(cmdRejected), 16'h0);
    $display("bank test done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole run needs about 90 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      badCount++;
      finishTest;
    end
  end
  initial begin
    srst = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    srst = 1'b0;
    testPower;
    testSref;
    testShutdown;
    testBanks;
    finishTest;
  end
endmodule // sdram_bank_cke_control_test

// ---- dv/sdram_ctl_model.sv ----
// Purpose: Controller command driver
// Assumes: issue called 1 ns after an edge
// Notes: Unused data lines show the inverse of the last word
`timescale 1ns/1ps
module sdram_ctl_model (
  input wire logic core_clk,
  output logic clockEnable,
  output logic chipSelectN,
  output logic rowStrobeN,
  output logic colStrobeN,
  output logic writeEnableN,
  output logic [sdram_ctl_pkg::BANK_W-1:0] bankAddr,
  output logic [sdram_ctl_pkg::ADDR_W-1:0] addr,
  output logic [sdram_ctl_pkg::DATA_W-1:0] dataIn
);
  // *****
  // Driver
  // *****
  initial begin
    clockEnable = 1'b1;
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = sdram_ctl_pkg::CMD_NOP;
    bankAddr = 2'h0;
    addr = 13'h0000;
    dataIn = 16'h0000;
  end
  task automatic issue(input logic [3:0] c, logic [1:0] b, logic ap, logic cke, logic dv,
    logic [15:0] d);
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = c;
    clockEnable = cke;
    bankAddr = b;
    addr = {2'h0, ap, 10'h000};
    dataIn = dv ? d : ~dataIn;
    @(posedge core_clk);
    #1;
  endtask
endmodule // sdram_ctl_model
